/* rtl/asc_cfg.svh */
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define ASC_FRAME_BITS     5'h10
`define ASC_LAST_BIT       5'h0f
`define ASC_NIBBLE_BIT     5'h03
`define ASC_RESULT_BITS    10
`define ASC_SETUP_BITS     12
`define ASC_HOST_PROBE     16'ha000

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define ASC_CMD_SLEEP      4'h8
`define ASC_CMD_READ_SETUP 4'h9
`define ASC_CMD_WRITE      4'ha
`define ASC_CMD_TEST_MID   4'hb
`define ASC_CMD_TEST_LOW   4'hc
`define ASC_CMD_TEST_HIGH  4'hd
`define ASC_CMD_FIFO_READ  4'he
`define ASC_CMD_RESERVED   4'hf

// ----------------------------------------------------------------
// Setup register fields and reset value
// ----------------------------------------------------------------
`define ASC_SETUP_RESET    12'h000
`define ASC_F_REF_SEL      11
`define ASC_F_REF_LVL      10
`define ASC_F_SAMPLE_LONG  9
`define ASC_F_CLK_HI       8
`define ASC_F_CLK_LO       7
`define ASC_F_MODE_HI      6
`define ASC_F_MODE_LO      5
`define ASC_F_SEQ_HI       4
`define ASC_F_SEQ_LO       3
`define ASC_F_EOC_SEL      2
`define ASC_F_TRIG_HI      1
`define ASC_F_TRIG_LO      0

// ----------------------------------------------------------------
// Decoded counts
// ----------------------------------------------------------------
`define ASC_SAMPLE_SHORT   5'h0c
`define ASC_SAMPLE_LONG    5'h18
`define ASC_DIV_OSC        3'h0
`define ASC_DIV_1          3'h1
`define ASC_DIV_2          3'h2
`define ASC_DIV_4          3'h4
`define ASC_TRIG_00        3'h7
`define ASC_TRIG_01        3'h5
`define ASC_TRIG_10        3'h3
`define ASC_TRIG_11        3'h1
`define ASC_SEL_TEST_MID   4'h8
`define ASC_SEL_TEST_LOW   4'h9
`define ASC_SEL_TEST_HIGH  4'ha

`endif

/* rtl/asc_pkg.sv */
package asc_pkg;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic frame_sync;
        logic sdi;
    } asc_link_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_DONE
    } asc_state_t;

endpackage

/* rtl/asc_serial_cmd.sv */
// Function
// - Frames are 16 bits MSB first; top nibble command, low twelve data.
// - Setup read returns four don't-care bits then the twelve setup bits.
// - Buffer read returns four don't-care bits, result in 11..2, two don't-care.
// - Conversion output puts 10-bit straight binary result in bits 15..6.
// - First result after power-up or wake is invalid and discarded.
// - Cycle starts at chip select fall with frame sync high, else frame sync fall.
// - Codes 0-7 pick channels; four-input build accepts only even codes.
// - Code 8 enters software power-down of analog and reference.
// - Code 9 reads back setup; meaningful only in one-shot mode 00.
// - Code A writes setup from the twelve following bits; code F reserved.
// - Codes B, C, D select midpoint, low and high reference test inputs.
// - Code E reads the result buffer; host pads the nibble with zeros.
// - Setup contents survive hardware and software power-down.
// - Setup write is 16 bits; a clock pause mid-frame is tolerated.
// - Bit 11 selects internal reference, bit 10 its level.
// - Bit 9 selects 12 or 24 clock sampling.
// - Bits 8:7 select oscillator, clock, clock/4 or clock/2 conversion clock.
// - Bits 6:5 select one-shot, repeat, sweep or repeat sweep.
// - Bits 4:3 select sweep channel order in sweep modes.
// - Bit 2 selects interrupt or end-of-conversion status pin function.
// - Bits 1:0 set trigger level 7, 5, 3 or 1 entries.
// - Capture on rising clock without frame sync, falling with it.
// - Stop capturing at 16 edges or chip select rise, whichever first.
// - Output floats while deselected, before first bit and after sixteenth.
`timescale 1ns/1ns
`default_nettype none
`include "asc_cfg.svh"

module asc_serial_cmd #(
    parameter bit EIGHT_CH = 1'b1
) (
    input  wire logic             CLK_I,
    input  wire logic             RESET_I,
    input  wire asc_pkg::asc_link_t LINK_I,
    input  wire logic             HW_SLEEP_N_I,
    input  wire logic [9:0]       RESULT_I,
    input  wire logic             RESULT_VALID_I,
    input  wire logic [9:0]       FIFO_WORD_I,
    input  wire logic [2:0]       SWEEP_STEP_I,
    output logic                  SDO_O,
    output logic                  SDO_OE_O,
    output logic [11:0]           CONVERTER_SETUP_O,
    output logic [3:0]            CHANNEL_SEL_O,
    output logic                  SELECT_PULSE_O,
    output logic                  SW_SLEEP_O,
    output logic                  FIFO_POP_O,
    output logic                  HOST_DSP_O,
    output logic                  RESULT_DISCARD_O,
    output logic [4:0]            SAMPLE_CLKS_O,
    output logic [2:0]            CONV_DIV_O,
    output logic [2:0]            TRIG_LEVEL_O,
    output logic [2:0]            SWEEP_CHAN_O
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [2:0] trig_of(input logic [1:0] code);
        case (code)
            2'h0:    trig_of = `ASC_TRIG_00;
            2'h1:    trig_of = `ASC_TRIG_01;
            2'h2:    trig_of = `ASC_TRIG_10;
            default: trig_of = `ASC_TRIG_11;
        endcase
    endfunction

    function automatic logic [2:0] sweep_of(input logic [1:0] seq, input logic [2:0] step);
        if (EIGHT_CH) begin
            case (seq)
                2'h0:    sweep_of = step;
                2'h1:    sweep_of = {step[1:0], 1'b0};
                2'h2:    sweep_of = {step[2:1], 1'b0};
                default: sweep_of = {1'b0, step[0], 1'b0};
            endcase
        end else begin
            case (seq)
                2'h1:    sweep_of = {1'b0, step[1:0]};
                2'h2:    sweep_of = {1'b0, step[2:1]};
                2'h3:    sweep_of = {2'b00, step[0]};
                default: sweep_of = 3'h0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Link edges
    // ----------------------------------------------------------------
    asc_pkg::asc_link_t prev_reg;
    asc_pkg::asc_state_t state_reg;
    logic        dsp_reg;
    logic [4:0]  bit_cnt_reg;
    logic [15:0] in_reg;
    logic [15:0] out_reg;
    logic [3:0]  cmd_reg;
    logic [9:0]  result_reg;
    logic [11:0] setup_reg;
    logic        first_reg;

    // Edges come from one stored sample; pins are synchronous, so no extra stage
    wire cs_fall   = prev_reg.cs_n & ~LINK_I.cs_n;
    wire cs_rise   = ~prev_reg.cs_n & LINK_I.cs_n;
    wire fs_fall   = prev_reg.frame_sync & ~LINK_I.frame_sync;
    wire sclk_rise = ~prev_reg.sclk & LINK_I.sclk;
    wire sclk_fall = prev_reg.sclk & ~LINK_I.sclk;
    wire start_spi = cs_fall & LINK_I.frame_sync;
    // A frame sync fall inside a frame is ignored, so a word is never restarted
    wire start_dsp = ~LINK_I.cs_n & fs_fall & (state_reg != asc_pkg::ST_SHIFT);
    wire start     = start_spi | start_dsp;
    wire shifting  = (state_reg == asc_pkg::ST_SHIFT) & ~cs_rise;
    wire cap_edge  = shifting & (dsp_reg ? sclk_fall : sclk_rise);
    // No shift before the first capture: the MSB must stand for a whole bit
    wire out_edge  = shifting & (bit_cnt_reg != 5'h00) & (dsp_reg ? sclk_rise : sclk_fall);
    wire cap_last  = cap_edge & (bit_cnt_reg == `ASC_LAST_BIT);
    wire nibble    = cap_edge & (bit_cnt_reg == `ASC_NIBBLE_BIT);

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    wire [3:0]  cmd_now   = {in_reg[2:0], LINK_I.sdi};
    wire [15:0] word_now  = {in_reg[14:0], LINK_I.sdi};
    wire        is_chan   = ~cmd_now[3] & (EIGHT_CH | ~cmd_now[0]);
    wire        is_test   = (cmd_now == `ASC_CMD_TEST_MID) | (cmd_now == `ASC_CMD_TEST_LOW)
                            | (cmd_now == `ASC_CMD_TEST_HIGH);
    wire [3:0]  chan_code = EIGHT_CH ? cmd_now : {2'b00, cmd_now[2:1]};
    wire [3:0]  test_code = (cmd_now == `ASC_CMD_TEST_MID) ? `ASC_SEL_TEST_MID :
                            (cmd_now == `ASC_CMD_TEST_LOW) ? `ASC_SEL_TEST_LOW : `ASC_SEL_TEST_HIGH;
    wire        do_sleep  = nibble & (cmd_now == `ASC_CMD_SLEEP);
    // Commit only at the sixteenth capture; a cut frame leaves setup alone
    wire        do_write  = cap_last & (cmd_reg == `ASC_CMD_WRITE);
    wire [11:0] setup_new = word_now[11:0];
    wire [11:0] payload   = (cmd_now == `ASC_CMD_READ_SETUP) ? setup_reg :
                            (cmd_now == `ASC_CMD_FIFO_READ)  ? {FIFO_WORD_I, 2'b00} :
                            out_reg[14:3];

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    wire [15:0] out_next = start    ? {result_reg, 6'h00} :
                           nibble   ? {out_reg[15], payload, out_reg[2:0]} :
                           out_edge ? {out_reg[14:0], 1'b0} : out_reg;
    wire sdo_next = start ? result_reg[9] : out_edge ? out_reg[14] : SDO_O;
    wire oe_next  = start | (SDO_OE_O & ~cs_rise & ~cap_last);
    asc_pkg::asc_state_t state_next;
    assign state_next = start    ? asc_pkg::ST_SHIFT :
                        cs_rise  ? asc_pkg::ST_IDLE :
                        cap_last ? asc_pkg::ST_DONE : state_reg;
    wire wake       = ~HW_SLEEP_N_I | do_sleep;
    wire first_next = wake | (first_reg & ~RESULT_VALID_I);

    // ----------------------------------------------------------------
    // Link state
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            // History starts deselected, so release shows no chip select rise
            prev_reg    <= '1;
            state_reg   <= asc_pkg::ST_IDLE;
            dsp_reg     <= 1'b0;
            bit_cnt_reg <= 5'h00;
            in_reg      <= 16'h0000;
            out_reg     <= 16'h0000;
            cmd_reg     <= 4'h0;
            SDO_O       <= 1'b0;
            SDO_OE_O    <= 1'b0;
        end else begin
            prev_reg    <= LINK_I;
            state_reg   <= state_next;
            dsp_reg     <= start ? start_dsp : dsp_reg;
            bit_cnt_reg <= start ? 5'h00 : cap_edge ? bit_cnt_reg + 5'h01 : bit_cnt_reg;
            in_reg      <= cap_edge ? word_now : in_reg;
            out_reg     <= out_next;
            cmd_reg     <= nibble ? cmd_now : cmd_reg;
            SDO_O       <= sdo_next;
            SDO_OE_O    <= oe_next;
        end
    end

    // ----------------------------------------------------------------
    // Setup register and command effects
    // ----------------------------------------------------------------
    // Only the reset and the write command touch setup; sleep paths leave it alone
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            setup_reg        <= `ASC_SETUP_RESET;
            CHANNEL_SEL_O    <= 4'h0;
            SELECT_PULSE_O   <= 1'b0;
            SW_SLEEP_O       <= 1'b0;
            FIFO_POP_O       <= 1'b0;
            HOST_DSP_O       <= 1'b0;
            first_reg        <= 1'b1;
            result_reg       <= 10'h000;
            RESULT_DISCARD_O <= 1'b0;
        end else begin
            setup_reg        <= do_write ? setup_new : setup_reg;
            CHANNEL_SEL_O    <= (nibble & is_chan) ? chan_code :
                                (nibble & is_test) ? test_code : CHANNEL_SEL_O;
            SELECT_PULSE_O   <= nibble & (is_chan | is_test);
            SW_SLEEP_O       <= do_sleep | (SW_SLEEP_O & ~start);
            FIFO_POP_O       <= nibble & (cmd_now == `ASC_CMD_FIFO_READ);
            HOST_DSP_O       <= (cap_last & (word_now == `ASC_HOST_PROBE)) ? dsp_reg : HOST_DSP_O;
            first_reg        <= first_next;
            result_reg       <= (RESULT_VALID_I & ~first_reg) ? RESULT_I : result_reg;
            RESULT_DISCARD_O <= RESULT_VALID_I & first_reg;
        end
    end

    // ----------------------------------------------------------------
    // Setup field decode
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            CONVERTER_SETUP_O <= `ASC_SETUP_RESET;
            SAMPLE_CLKS_O     <= `ASC_SAMPLE_SHORT;
            CONV_DIV_O        <= `ASC_DIV_OSC;
            TRIG_LEVEL_O      <= `ASC_TRIG_00;
            SWEEP_CHAN_O      <= 3'h0;
        end else begin
            CONVERTER_SETUP_O <= setup_reg;
            SAMPLE_CLKS_O     <= setup_reg[`ASC_F_SAMPLE_LONG] ? `ASC_SAMPLE_LONG : `ASC_SAMPLE_SHORT;
            case (setup_reg[`ASC_F_CLK_HI:`ASC_F_CLK_LO])
                2'h0:    CONV_DIV_O <= `ASC_DIV_OSC;
                2'h1:    CONV_DIV_O <= `ASC_DIV_1;
                2'h2:    CONV_DIV_O <= `ASC_DIV_4;
                default: CONV_DIV_O <= `ASC_DIV_2;
            endcase
            // One-shot mode ignores the trigger level
            TRIG_LEVEL_O <= (setup_reg[`ASC_F_MODE_HI:`ASC_F_MODE_LO] == 2'h0) ? 3'h0 :
                            trig_of(setup_reg[`ASC_F_TRIG_HI:`ASC_F_TRIG_LO]);
            SWEEP_CHAN_O <= setup_reg[`ASC_F_MODE_HI] ?
                            sweep_of(setup_reg[`ASC_F_SEQ_HI:`ASC_F_SEQ_LO], SWEEP_STEP_I) : 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    AST_SETUP_WRITE: assert property (do_write |-> ##2 CONVERTER_SETUP_O == $past(setup_new, 2))
        else $error("setup write not applied");
    AST_OE_AFTER_LAST: assert property (cap_last |=> !SDO_OE_O)
        else $error("output still driven after sixteenth bit");
    AST_CS_RISE_STOP: assert property (cs_rise |=> !SDO_OE_O && state_reg == asc_pkg::ST_IDLE)
        else $error("chip select rise did not end frame");
    AST_START_MSB: assert property (start |=> SDO_OE_O && SDO_O == $past(result_reg[9]))
        else $error("result msb not presented at start");
    AST_SLEEP_ENTRY: assert property (do_sleep |=> SW_SLEEP_O && first_reg)
        else $error("sleep command not taken");
    AST_SETUP_HOLD: assert property (!do_write |=> $stable(setup_reg))
        else $error("setup changed without a write");
    AST_TEST_SELECT: assert property (nibble && cmd_now == `ASC_CMD_TEST_LOW
                                      |=> CHANNEL_SEL_O == `ASC_SEL_TEST_LOW)
        else $error("low reference test not selected");
    AST_ODD_CHANNEL: assert property (nibble && !EIGHT_CH && !cmd_now[3] && cmd_now[0] |=> !SELECT_PULSE_O)
        else $error("odd channel accepted on four-input build");
    AST_READBACK: assert property (nibble && cmd_now == `ASC_CMD_READ_SETUP
                                   |=> out_reg[14:3] == $past(setup_reg))
        else $error("setup readback misplaced");
    AST_FIFO_READ: assert property (nibble && cmd_now == `ASC_CMD_FIFO_READ
                                    |=> FIFO_POP_O && out_reg[14:3] == {$past(FIFO_WORD_I), 2'b00})
        else $error("buffer word misplaced");
    AST_DISCARD: assert property (RESULT_VALID_I && first_reg |=> $stable(result_reg) && RESULT_DISCARD_O)
        else $error("first result not discarded");

    // Framing: one start, sixteen captures, nothing outside a frame
    AST_START_COUNT: assert property (start
                                      |=> bit_cnt_reg == 5'h00 && state_reg == asc_pkg::ST_SHIFT)
        else $error("frame start did not clear the bit count");
    AST_NO_EXTRA_CAPTURE: assert property (state_reg != asc_pkg::ST_SHIFT && !start
                                           |=> $stable(bit_cnt_reg) && $stable(in_reg))
        else $error("bit captured outside a frame");
    AST_CS_ABORT: assert property (cs_rise && state_reg == asc_pkg::ST_SHIFT
                                   |=> state_reg == asc_pkg::ST_IDLE && $stable(setup_reg))
        else $error("cut frame changed setup");
    AST_SDO_HOLD: assert property (!start && !out_edge |=> $stable(SDO_O))
        else $error("serial output moved between shift edges");

    // Command effects
    AST_CHANNEL_SELECT: assert property (nibble && EIGHT_CH && !cmd_now[3]
                                         |=> SELECT_PULSE_O && CHANNEL_SEL_O == $past(cmd_now))
        else $error("channel command not selected");
    AST_POP_ONCE: assert property (FIFO_POP_O |=> !FIFO_POP_O)
        else $error("buffer popped twice for one command");
    AST_SLEEP_CLEAR: assert property (SW_SLEEP_O && start |=> !SW_SLEEP_O)
        else $error("sleep not left at frame start");
    AST_HOST_PROBE: assert property (cap_last && word_now == `ASC_HOST_PROBE
                                     |=> HOST_DSP_O == $past(dsp_reg))
        else $error("host type not latched");

    // Field decode follows the stored setup one cycle later
    AST_SETUP_COPY: assert property (1'b1 |=> CONVERTER_SETUP_O == $past(setup_reg))
        else $error("setup copy lags");
    AST_SAMPLE_LONG: assert property (setup_reg[`ASC_F_SAMPLE_LONG] |=> SAMPLE_CLKS_O == `ASC_SAMPLE_LONG)
        else $error("long sampling not decoded");
    AST_DIV_QUARTER: assert property (setup_reg[`ASC_F_CLK_HI:`ASC_F_CLK_LO] == 2'h2
                                      |=> CONV_DIV_O == `ASC_DIV_4)
        else $error("quarter clock not decoded");
    AST_TRIG_FULL: assert property (setup_reg[`ASC_F_MODE_HI:`ASC_F_MODE_LO] != 2'h0
                                    && setup_reg[`ASC_F_TRIG_HI:`ASC_F_TRIG_LO] == 2'h0
                                    |=> TRIG_LEVEL_O == `ASC_TRIG_00)
        else $error("full trigger level not decoded");
    AST_SWEEP_IDLE: assert property (!setup_reg[`ASC_F_MODE_HI] |=> SWEEP_CHAN_O == 3'h0)
        else $error("sweep order used outside sweep modes");

    COV_SPI_FRAME: cover property (start_spi ##[1:400] cap_last);
    COV_DSP_FRAME: cover property (start_dsp ##[1:400] cap_last);
    COV_WRITE:     cover property (do_write);
    COV_SLEEP:     cover property (do_sleep);
    COV_READBACK:  cover property (nibble && cmd_now == `ASC_CMD_READ_SETUP);

endmodule // asc_serial_cmd
`default_nettype wire

/* bench/asc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------
// Host serial port model
// ------------------------
module asc_host_model (
    input  wire logic              clk_i,
    input  wire logic              sdo_i,
    input  wire logic              sdo_oe_i,
    output var asc_pkg::asc_link_t link_o
);
    initial link_o = '{cs_n: 1'b1, sclk: 1'b0, frame_sync: 1'b1, sdi: 1'b0};

    // Clock stands still outside frames; an undriven output reads as z
    task automatic xfer(input logic [15:0] w, input bit dsp, input int nbits, input bit pause,
                        output logic [15:0] rd);
        rd = 16'h0000;
        link_o.frame_sync <= ~dsp;
        link_o.sclk       <= dsp;
        @(posedge clk_i);
        link_o.cs_n <= 1'b0;
        if (dsp) begin
            repeat (2) @(posedge clk_i);
            link_o.frame_sync <= 1'b1;
            repeat (2) @(posedge clk_i);
            link_o.frame_sync <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
        for (int i = 15; i >= 16 - nbits; i--) begin
            link_o.sdi <= w[i];
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            rd[i] = sdo_oe_i ? sdo_i : 1'bz;
            @(posedge clk_i);
            link_o.sclk <= ~link_o.sclk;
            repeat (3) @(posedge clk_i);
            link_o.sclk <= ~link_o.sclk;
            if (pause && i == 8) repeat (20) @(posedge clk_i);
        end
        repeat (3) @(posedge clk_i);
        // Released data line flips so a stale bit never passes for data
        link_o <= '{cs_n: 1'b1, sclk: 1'b0, frame_sync: 1'b1, sdi: ~link_o.sdi};
        repeat (4) @(posedge clk_i);
    endtask
endmodule // asc_host_model
`default_nettype wire

/* bench/adc_serial_command_config_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "asc_cfg.svh"
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD %s exp=%h seen=%h", nm, exp, got); end end
// ------------------------
// Testbench
// ------------------------
module adc_serial_command_config_tb;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    asc_pkg::asc_link_t link;
    logic               hw_sleep_n = 1'b1;
    logic               res_valid = 1'b0;
    logic [9:0]         res = 10'h000;
    logic [9:0]         fifo_word = 10'h000;
    logic [2:0]         sweep_step = 3'h0;
    logic               sdo, sdo_oe, sel_p, sleep, pop, host_dsp, drop;
    logic [11:0]        setup;
    logic [3:0]         chan;
    logic [4:0]         samp;
    logic [2:0]         div, trig, swch;
    logic [15:0]        rd;
    int                 n_fail = 0, samples_checked = 0, n_sel = 0, n_pop = 0, n_drop = 0;

    initial forever #25 clk = ~clk;

    always @(posedge clk) begin
        n_sel  <= n_sel + int'(sel_p === 1'b1);
        n_pop  <= n_pop + int'(pop === 1'b1);
        n_drop <= n_drop + int'(drop === 1'b1);
    end

    asc_host_model host_u (.clk_i(clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .link_o(link));

    asc_serial_cmd dut_u (
        .CLK_I(clk), .RESET_I(rst), .LINK_I(link), .HW_SLEEP_N_I(hw_sleep_n),
        .RESULT_I(res), .RESULT_VALID_I(res_valid), .FIFO_WORD_I(fifo_word),
        .SWEEP_STEP_I(sweep_step), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .CONVERTER_SETUP_O(setup),
        .CHANNEL_SEL_O(chan), .SELECT_PULSE_O(sel_p), .SW_SLEEP_O(sleep), .FIFO_POP_O(pop),
        .HOST_DSP_O(host_dsp), .RESULT_DISCARD_O(drop), .SAMPLE_CLKS_O(samp),
        .CONV_DIV_O(div), .TRIG_LEVEL_O(trig), .SWEEP_CHAN_O(swch)
    );

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic frame(input logic [15:0] w, input bit dsp = 0, input int nbits = 16, input bit pause = 0);
        int k;
        @(posedge clk);
        host_u.xfer(w, dsp, nbits, pause, rd);
        for (k = 0; k < 10 && sdo_oe !== 1'b0; k++) @(posedge clk);
        if (k == 10) begin
            n_fail++;
            $display("BAD sdo_oe release exp=0 seen=%b", sdo_oe);
            report_and_stop();
        end
        @(negedge clk);
        `CHK("sdo_oe idle", 1'b0, sdo_oe)
    endtask

    task automatic push(input logic [9:0] v);
        @(posedge clk);
        res       <= v;
        res_valid <= 1'b1;
        @(posedge clk);
        res_valid <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_probe();
        `CHK("setup rst", `ASC_SETUP_RESET, setup)
        frame(`ASC_HOST_PROBE);
        `CHK("spi host", 1'b0, host_dsp)
        push(10'h155);
        `CHK("first dropped", 1, n_drop)
        push(10'h2c7);
        `CHK("second kept", 1, n_drop)
        frame(16'h0000);
        `CHK("conv word", 10'h2c7, rd[15:6])
    endtask

    task automatic t_setup();
        logic [2:0] dv[4] = '{`ASC_DIV_OSC, `ASC_DIV_1, `ASC_DIV_4, `ASC_DIV_2};
        logic [2:0] tg[4] = '{`ASC_TRIG_00, `ASC_TRIG_01, `ASC_TRIG_10, `ASC_TRIG_11};
        logic [2:0] sw[4] = '{3'h3, 3'h6, 3'h2, 3'h2};
        logic [1:0] c;
        logic [11:0] cfg;
        frame({`ASC_CMD_WRITE, 12'hb6b}, 0, 16, 1);
        `CHK("paused write", 12'hb6b, setup)
        @(posedge clk);
        sweep_step <= 3'h3;
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            cfg = {2'b11, c[0], c, 1'b1, c[1], c, 1'b1, c};
            frame({`ASC_CMD_WRITE, cfg});
            `CHK("setup", cfg, setup)
            `CHK("sample", c[0] ? `ASC_SAMPLE_LONG : `ASC_SAMPLE_SHORT, samp)
            `CHK("div", dv[k], div)
            `CHK("trig", tg[k], trig)
            `CHK("sweep", sw[k], swch)
        end
        frame({`ASC_CMD_WRITE, 12'h03b});
        `CHK("trig repeat", `ASC_TRIG_11, trig)
        `CHK("sweep repeat", 3'h0, swch)
        frame({`ASC_CMD_WRITE, 12'h01b});
        `CHK("trig one shot", 3'h0, trig)
        `CHK("sweep one shot", 3'h0, swch)
        frame({`ASC_CMD_WRITE, 12'hfff}, 0, 8);
        `CHK("aborted write", 12'h01b, setup)
        frame({`ASC_CMD_READ_SETUP, 12'h000}, 1);
        `CHK("readback", 12'h01b, rd[11:0])
    endtask

    task automatic t_select();
        int s0;
        for (int k = 0; k < 11; k++) begin
            s0 = n_sel;
            frame({4'(k < 8 ? k : k + 3), 12'h000});
            `CHK("chan", 4'(k), chan)
            `CHK("sel pulse", s0 + 1, n_sel)
            `CHK("conv word", 10'h2c7, rd[15:6])
        end
        frame({`ASC_CMD_RESERVED, 12'h000});
        `CHK("reserved chan", `ASC_SEL_TEST_HIGH, chan)
        `CHK("reserved pulse", s0 + 1, n_sel)
    endtask

    task automatic t_fifo_sleep();
        int s0;
        @(posedge clk);
        fifo_word <= 10'h2a5;
        s0 = n_pop;
        frame({`ASC_CMD_FIFO_READ, 12'h000});
        `CHK("fifo word", 10'h2a5, rd[11:2])
        `CHK("fifo tail", 2'h0, rd[1:0])
        `CHK("fifo pop", s0 + 1, n_pop)
        s0 = n_drop;
        frame({`ASC_CMD_SLEEP, 12'h000});
        `CHK("sw sleep", 1'b1, sleep)
        push(10'h3ff);
        `CHK("wake drop", s0 + 1, n_drop)
        @(posedge clk);
        hw_sleep_n <= 1'b0;
        repeat (4) @(posedge clk);
        hw_sleep_n <= 1'b1;
        push(10'h0aa);
        `CHK("hw wake drop", s0 + 2, n_drop)
        `CHK("setup kept", 12'h01b, setup)
        frame(16'h0000);
        `CHK("sleep cleared", 1'b0, sleep)
        `CHK("old result", 10'h2c7, rd[15:6])
        frame(`ASC_HOST_PROBE, 1);
        `CHK("dsp host", 1'b1, host_dsp)
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_probe();
        t_setup();
        t_select();
        t_fifo_sleep();
        report_and_stop();
    end
endmodule // adc_serial_command_config_tb
`default_nettype wire
